// ==== src/stfc_tx_fifo_ctrl.sv ====
// spi transmit fifo control and status with an axi4-lite register slave
//
// Chosen here: the AXI4-Lite slave port.
module stfc_tx_fifo_ctrl
   import stfc_pkg::*;
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // axi4-lite write data
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // axi4-lite write response
   output logic      [1:0]        s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // axi4-lite read data
   output logic      [DATA_W-1:0] s_axi_rdata,
   output logic      [1:0]        s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // serial channel side
   output logic                   channel_reset_n,
   output logic                   fifo_mode_enable,
   output logic      [WORD_W-1:0] tx_word_data,
   output logic                   tx_word_valid,
   input  wire logic              tx_word_taken,
   // interrupts
   output logic                   tx_level_irq,
   output logic                   irq
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic stfc_sel_t reg_sel(input logic [ADDR_W-1:0] addr);
      logic [IDX_W-1:0] idx;
      idx = addr[ADDR_W-1:2];
      case (idx)
         IDX_TX_CTRL:  return SEL_TX_CTRL;
         IDX_RX_CTRL:  return SEL_RX_CTRL;
         IDX_TX_DATA:  return SEL_TX_DATA;
         IDX_IRQ_STAT: return SEL_IRQ_STAT;
         IDX_IRQ_MASK: return SEL_IRQ_MASK;
         default:      return SEL_NONE;
      endcase
   endfunction

   function automatic logic [REG_W-1:0] lane_merge(input logic [REG_W-1:0] old_v,
                                                   input logic [REG_W-1:0] new_v,
                                                   input logic [1:0]       strb);
      return {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
   endfunction

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic              aw_hold_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic              w_hold_ff;
   logic [DATA_W-1:0] wdata_ff;
   logic [3:0]        wstrb_ff;
   logic              bvalid_ff;
   logic [1:0]        bresp_ff;
   logic              rvalid_ff;
   logic [1:0]        rresp_ff;
   logic [DATA_W-1:0] rdata_ff;

   logic              chrst_ff;
   logic              fena_ff;
   logic              tprst_ff;
   logic              iena_ff;
   logic [THR_W-1:0]  thr_ff;
   logic              flag_ff;
   logic [REG_W-1:0]  rxc_ff;
   logic [EV_W-1:0]   stat_ff;
   logic [EV_W-1:0]   mask_ff;

   logic              aw_fire;
   logic              w_fire;
   logic              wr_fire;
   logic              ar_fire;
   stfc_sel_t         wr_sel;
   stfc_sel_t         ar_sel;
   logic              wr_txc;
   logic [REG_W-1:0]  txc_view;
   logic [REG_W-1:0]  nxt_txc;
   logic              irq_clr;
   logic [DATA_W-1:0] rd_word;

   logic              flush;
   logic              full;
   logic              push_req;
   logic              push;
   logic              drop;
   logic              pop;
   logic              level_hit;
   logic [EV_W-1:0]   ev;
   logic [CNT_W-1:0]  fifo_count;

   // ------------------------------------------------------------
   // axi4-lite write channel
   // ------------------------------------------------------------
   assign aw_fire       = s_axi_awvalid && s_axi_awready;
   assign w_fire        = s_axi_wvalid && s_axi_wready;
   assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
   assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
   // address and data may come in either order; act once both are held
   assign wr_fire       = aw_hold_ff && w_hold_ff && !bvalid_ff;
   assign wr_sel        = reg_sel(awaddr_ff);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_ff <= 1'b0;
         awaddr_ff  <= '0;
      end else if (aw_fire) begin
         aw_hold_ff <= 1'b1;
         awaddr_ff  <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_hold_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold_ff <= 1'b0;
         wdata_ff  <= '0;
         wstrb_ff  <= 4'h0;
      end else if (w_fire) begin
         w_hold_ff <= 1'b1;
         wdata_ff  <= s_axi_wdata;
         wstrb_ff  <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_hold_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp  = bresp_ff;

   // ------------------------------------------------------------
   // axi4-lite read channel
   // ------------------------------------------------------------
   assign s_axi_arready = !rvalid_ff;
   assign ar_fire       = s_axi_arvalid && s_axi_arready;
   assign ar_sel        = reg_sel(s_axi_araddr);

   always_comb begin
      rd_word = '0;
      case (ar_sel)
         SEL_TX_CTRL:  rd_word[REG_W-1:0] = txc_view;
         SEL_RX_CTRL:  rd_word[REG_W-1:0] = rxc_ff;
         SEL_IRQ_STAT: rd_word[EV_W-1:0]  = stat_ff;
         SEL_IRQ_MASK: rd_word[EV_W-1:0]  = mask_ff;
         default:      rd_word = '0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rresp_ff  <= RESP_OKAY;
         rdata_ff  <= '0;
      end else if (ar_fire) begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= (ar_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         rdata_ff  <= rd_word;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp  = rresp_ff;
   assign s_axi_rdata  = rdata_ff;

   // ------------------------------------------------------------
   // tx_fifo_control register
   // ------------------------------------------------------------
   // the clear position is a constant zero, so it always reads back zero
   assign txc_view = {chrst_ff, fena_ff, tprst_ff, fifo_count,
                      flag_ff, 1'b0, iena_ff, thr_ff};
   assign wr_txc   = wr_fire && (wr_sel == SEL_TX_CTRL);
   assign nxt_txc  = lane_merge(txc_view, wdata_ff[REG_W-1:0], wstrb_ff[1:0]);
   assign irq_clr  = wr_txc && nxt_txc[CLR_BIT];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chrst_ff <= CHRST_RST;
         fena_ff  <= FENA_RST;
         tprst_ff <= TPRST_RST;
         iena_ff  <= IENA_RST;
         thr_ff   <= THR_RST;
      end else if (wr_txc) begin
         chrst_ff <= nxt_txc[CHRST_BIT];
         fena_ff  <= nxt_txc[FENA_BIT];
         tprst_ff <= nxt_txc[TPRST_BIT];
         iena_ff  <= nxt_txc[IENA_BIT];
         thr_ff   <= nxt_txc[THR_LSB +: THR_W];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rxc_ff <= RX_CTRL_RST;
      end else if (wr_fire && (wr_sel == SEL_RX_CTRL)) begin
         rxc_ff <= lane_merge(rxc_ff, wdata_ff[REG_W-1:0], wstrb_ff[1:0]) & RX_CTRL_WMASK;
      end
   end

   assign channel_reset_n  = chrst_ff;
   assign fifo_mode_enable = fena_ff;

   // ------------------------------------------------------------
   // transmit fifo
   // ------------------------------------------------------------
   // a channel reset also empties the fifo; the settings are kept
   assign flush    = !chrst_ff || !tprst_ff;
   // without enhancements the fifo acts as a single-word buffer
   assign full     = fifo_count >= (fena_ff ? CNT_W'(FIFO_DEPTH) : CNT_W'(1));
   assign push_req = wr_fire && (wr_sel == SEL_TX_DATA) && (wstrb_ff[1:0] != 2'h0);
   assign push     = push_req && !full && !flush;
   assign drop     = push_req && full && !flush;
   assign tx_word_valid = (fifo_count != '0) && !flush;
   assign pop      = tx_word_taken && tx_word_valid;

   stfc_word_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (aclk),
      .rst_n     (aresetn),
      .flush     (flush),
      .push      (push),
      .push_data (wdata_ff[WORD_W-1:0]),
      .pop       (pop),
      .head_data (tx_word_data),
      .count     (fifo_count)
   );

   // ------------------------------------------------------------
   // level-match interrupt
   // ------------------------------------------------------------
   assign level_hit = fena_ff && (fifo_count <= thr_ff);

   // the condition is a level, so it wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_ff <= 1'b0;
      end else if (level_hit) begin
         flag_ff <= 1'b1;
      end else if (irq_clr) begin
         flag_ff <= 1'b0;
      end
   end

   assign tx_level_irq = flag_ff && iena_ff;

   // ------------------------------------------------------------
   // interrupt status and mask
   // ------------------------------------------------------------
   always_comb begin
      ev           = '0;
      ev[EV_LEVEL] = level_hit && !flag_ff;
      ev[EV_DROP]  = drop;
   end

   // a read clears status, but an event in that same cycle survives
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_ff <= '0;
      end else if (ar_fire && (ar_sel == SEL_IRQ_STAT)) begin
         stat_ff <= ev;
      end else begin
         stat_ff <= stat_ff | ev;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_ff <= '0;
      end else if (wr_fire && (wr_sel == SEL_IRQ_MASK) && wstrb_ff[0]) begin
         mask_ff <= wdata_ff[EV_W-1:0];
      end
   end

   assign irq = |(stat_ff & mask_ff);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_chan_reset_flush: assert property (
      (wr_txc && !nxt_txc[CHRST_BIT]) |=> !channel_reset_n && !tx_word_valid
                                          ##1 (fifo_count == '0))
      else $error("channel reset did not stop and empty the fifo");

   a_chan_resume: assert property (
      (chrst_ff && tprst_ff && (fifo_count != '0)) |-> tx_word_valid)
      else $error("fifo holds words but offers none after resume");

   a_mode_off_quiet: assert property (
      (!fena_ff && !flag_ff && !$past(fena_ff)) |=> !flag_ff || fena_ff)
      else $error("level flag set with fifo enhancements off");

   a_pointer_held: assert property (
      (!tprst_ff && $past(!tprst_ff)) |-> (fifo_count == '0) && !tx_word_valid)
      else $error("fifo not held empty under pointer reset");

   a_count_readback: assert property (
      (ar_fire && (ar_sel == SEL_TX_CTRL))
      |=> (s_axi_rdata[CNT_LSB +: CNT_W] == $past(fifo_count))
          && (s_axi_rdata[FLAG_BIT] == $past(flag_ff)))
      else $error("fill count or flag read back wrong");

   a_clear_reads_zero: assert property (
      (ar_fire && (ar_sel == SEL_TX_CTRL)) |=> !s_axi_rdata[CLR_BIT])
      else $error("interrupt clear bit read back nonzero");

   a_flag_cleared: assert property (
      (irq_clr && !level_hit) |=> !flag_ff)
      else $error("flag not cleared by write of one");

   a_flag_set: assert property (
      level_hit |=> flag_ff)
      else $error("flag not set at or below threshold");

   a_irq_forward: assert property (
      ($rose(flag_ff) && iena_ff) |-> tx_level_irq ##0 !$past(tx_level_irq))
      else $error("enabled level interrupt not forwarded");

   a_thr_reset: assert property (
      $rose(aresetn) |-> (thr_ff == '0) && (s_axi_bvalid == 1'b0))
      else $error("threshold not zero after reset");

   a_count_step: assert property (
      (push && !pop) |=> (fifo_count == $past(fifo_count) + CNT_W'(1)))
      else $error("fill count did not step up on write");

   a_count_drain: assert property (
      (pop && !push && !flush) |=> (fifo_count == $past(fifo_count) - CNT_W'(1)))
      else $error("fill count did not step down on shift");

   a_bresp_stable: assert property (
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before bready");

endmodule

// ==== pkg/stfc_pkg.sv ====
// constants, types and register map of the spi transmit fifo control block
package stfc_pkg;

   // ------------------------------------------------------------
   // register bus
   // ------------------------------------------------------------
   localparam int ADDR_W = 20;
   localparam int IDX_W  = 18;
   localparam int DATA_W = 32;
   localparam int REG_W  = 16;

   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_TX_CTRL  = 18'h0704A;
   localparam logic [IDX_W-1:0] IDX_RX_CTRL  = 18'h0704B;
   localparam logic [IDX_W-1:0] IDX_TX_DATA  = 18'h0704C;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 18'h0704D;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 18'h0704E;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // transmit fifo
   // ------------------------------------------------------------
   localparam int FIFO_DEPTH = 16;
   localparam int WORD_W     = 16;
   localparam int CNT_W      = 5;
   localparam int THR_W      = 5;

   // tx_fifo_control field positions
   localparam int CHRST_BIT = 15;
   localparam int FENA_BIT  = 14;
   localparam int TPRST_BIT = 13;
   localparam int CNT_LSB   = 8;
   localparam int FLAG_BIT  = 7;
   localparam int CLR_BIT   = 6;
   localparam int IENA_BIT  = 5;
   localparam int THR_LSB   = 0;

   // values after reset
   localparam logic             CHRST_RST = 1'b1;
   localparam logic             FENA_RST  = 1'b0;
   localparam logic             TPRST_RST = 1'b1;
   localparam logic             IENA_RST  = 1'b0;
   localparam logic [THR_W-1:0] THR_RST   = 5'h00;

   // rx_fifo_control is held by layout only
   localparam logic [REG_W-1:0] RX_CTRL_WMASK = 16'h203F;
   localparam logic [REG_W-1:0] RX_CTRL_RST   = 16'h201F;

   // ------------------------------------------------------------
   // interrupt status events
   // ------------------------------------------------------------
   localparam int EV_W     = 2;
   localparam int EV_LEVEL = 0;
   localparam int EV_DROP  = 1;

   typedef enum logic [2:0] {
      SEL_TX_CTRL  = 3'h0,
      SEL_RX_CTRL  = 3'h1,
      SEL_TX_DATA  = 3'h2,
      SEL_IRQ_STAT = 3'h3,
      SEL_IRQ_MASK = 3'h4,
      SEL_NONE     = 3'h7
   } stfc_sel_t;

endpackage

// ==== src/stfc_word_fifo.sv ====
// word storage and fill count of the transmit fifo
module stfc_word_fifo #(
   parameter  int WIDTH = 16,
   parameter  int DEPTH = 16,
   localparam int PW    = $clog2(DEPTH),
   localparam int CW    = PW + 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // control
   input  wire logic             flush,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] push_data,
   input  wire logic             pop,
   // state
   output logic      [WIDTH-1:0] head_data,
   output logic      [CW-1:0]    count
);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0]    wr_ptr_ff;
   logic [PW-1:0]    rd_ptr_ff;
   logic [CW-1:0]    count_ff;

   // pointers wrap by width, so depth must be a power of two
   always_ff @(posedge clk) begin
      if (!rst_n || flush) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + PW'(1);
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + PW'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || flush) begin
         count_ff <= '0;
      end else if (push && !pop) begin
         count_ff <= count_ff + CW'(1);
      end else if (pop && !push) begin
         count_ff <= count_ff - CW'(1);
      end
   end

   // storage needs no reset; the count says what is valid
   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= push_data;
      end
   end

   assign head_data = mem_ff[rd_ptr_ff];
   assign count     = count_ff;

endmodule

// ==== dv/stfc_shift_model.sv ====
// far-side shift engine model that takes words from the transmit fifo
module stfc_shift_model
   import stfc_pkg::*;
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // word handshake
   input  wire logic [WORD_W-1:0] tx_word_data,
   input  wire logic              tx_word_valid,
   output logic                   tx_word_taken,
   // pacing and observation
   input  wire logic              stall,
   input  wire logic              slow,
   output logic                   got_stb,
   output logic      [WORD_W-1:0] got_word
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [1:0] gap_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_word_taken <= 1'b0;
         gap_ff        <= 2'h0;
         got_stb       <= 1'b0;
      end else begin
         // a word leaves only when both sides agree at the same edge
         got_stb  <= tx_word_taken && tx_word_valid;
         got_word <= tx_word_data;
         if (tx_word_taken && tx_word_valid) begin
            tx_word_taken <= 1'b0;
            gap_ff        <= slow ? 2'h3 : 2'h0;
         end else if (gap_ff != 2'h0) begin
            gap_ff <= gap_ff - 2'h1;
         end else begin
            tx_word_taken <= tx_word_valid && !stall;
         end
      end
   end
endmodule

// ==== dv/tb.sv ====
// self-checking bench for the spi transmit fifo control block
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
   $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb
   import stfc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [ADDR_W-1:0] A_CTL = {IDX_TX_CTRL, 2'b00};
   localparam logic [ADDR_W-1:0] A_RX  = {IDX_RX_CTRL, 2'b00};
   localparam logic [ADDR_W-1:0] A_DAT = {IDX_TX_DATA, 2'b00};
   localparam logic [ADDR_W-1:0] A_STA = {IDX_IRQ_STAT, 2'b00};
   localparam logic [ADDR_W-1:0] A_MSK = {IDX_IRQ_MASK, 2'b00};
   localparam logic [ADDR_W-1:0] A_BAD = 20'h00100;

   logic              aclk, aresetn, stall, slow, got_stb;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [3:0]        s_axi_wstrb;
   logic [1:0]        s_axi_bresp, s_axi_rresp, resp;
   logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic              s_axi_rvalid, s_axi_rready, channel_reset_n, fifo_mode_enable;
   logic              tx_word_valid, tx_word_taken, tx_level_irq, irq;
   logic [WORD_W-1:0] tx_word_data, got_word, w_exp;
   logic [4:0]        thr;
   logic [WORD_W-1:0] q[$];
   int                n_fail, checks_done, n;

   stfc_tx_fifo_ctrl i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .channel_reset_n, .fifo_mode_enable,
      .tx_word_data, .tx_word_valid, .tx_word_taken, .tx_level_irq, .irq);

   stfc_shift_model i_shift (.aclk, .aresetn, .tx_word_data, .tx_word_valid, .tx_word_taken,
      .stall, .slow, .got_stb, .got_word);

   // ------
   // bus tasks and expectations
   // ------
   function automatic logic [DATA_W-1:0] ctl(int ch, fe, tp, cl, ie, logic [4:0] th);
      return {16'h0000, 1'(ch), 1'(fe), 1'(tp), 5'h00, 1'b0, 1'(cl), 1'(ie), th};
   endfunction

   // clear bit always reads zero
   function automatic logic [DATA_W-1:0] ectl(int ch, fe, tp, logic [4:0] c,
                                              int fl, ie, logic [4:0] th);
      return {16'h0000, 1'(ch), 1'(fe), 1'(tp), c, 1'(fl), 1'b0, 1'(ie), th};
   endfunction

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic ah, wh, bh;
      // requests always start just after a rising edge
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      bh = 1'b0;
      while (!bh) begin
         // sampled mid-cycle: nothing moves between here and the next edge
         @(negedge aclk);
         ah = s_axi_awvalid && s_axi_awready;
         wh = s_axi_wvalid && s_axi_wready;
         bh = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge aclk);
         if (ah) s_axi_awvalid <= 1'b0;
         if (wh) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      // return mid-cycle so callers look at settled outputs
      @(negedge aclk);
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a);
      logic ah, rh;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      rh = 1'b0;
      while (!rh) begin
         @(negedge aclk);
         ah = s_axi_arvalid && s_axi_arready;
         rh = s_axi_rvalid;
         rdat = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge aclk);
         if (ah) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      @(negedge aclk);
   endtask

   task automatic push(input logic [WORD_W-1:0] w);
      q.push_back(w);
      wr(A_DAT, {16'h0000, w});
   endtask

   task automatic drained;
      while (tx_word_valid !== 1'b0) @(negedge aclk);
      repeat (3) @(negedge aclk);
   endtask

   task automatic conclude;
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(negedge aclk) begin
      if (got_stb) begin
         w_exp = q.pop_front();
         `CHK(got_word, w_exp)
      end
   end

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      conclude;
   end

   // ------
   // main sequence
   // ------
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      aresetn = 1'b0;
      stall = 1'b1;
      slow = 1'b0;
      void'($urandom(32'h533C));
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(A_CTL);
      `CHK(rdat, 32'h0000A000)
      `CHK(channel_reset_n, 1'b1)
      rd(A_RX);
      `CHK(rdat, {16'h0000, RX_CTRL_RST})
      // configuration that a channel reset must leave alone
      wr(A_RX, 32'h0000FFFF);
      rd(A_BAD);
      `CHK(resp, RESP_SLVERR)
      wr(A_BAD, 32'h0000FFFF);
      `CHK(resp, RESP_SLVERR)
      // enhancements off: one-word buffer, flag may not set
      wr(A_CTL, ctl(1, 0, 1, 0, 0, 5'h1F));
      push(16'($urandom));
      wr(A_DAT, 32'h00001234);
      rd(A_CTL);
      `CHK(rdat, ectl(1, 0, 1, 5'h01, 0, 0, 5'h1F))
      `CHK(irq, 1'b0)
      rd(A_STA);
      `CHK(rdat, 32'h00000002)
      wr(A_CTL, ctl(1, 0, 0, 0, 0, 5'h1F));
      q.delete();
      wr(A_DAT, 32'h00005A5A);
      rd(A_CTL);
      `CHK(rdat, ectl(1, 0, 0, 5'h00, 0, 0, 5'h1F))
      `CHK(tx_word_valid, 1'b0)
      wr(A_CTL, ctl(1, 1, 1, 0, 0, 5'h00));
      wr(A_MSK, 32'h00000003);
      rd(A_CTL);
      `CHK(rdat, ectl(1, 1, 1, 5'h00, 1, 0, 5'h00))
      `CHK(fifo_mode_enable, 1'b1)
      `CHK(tx_level_irq, 1'b0)
      `CHK(irq, 1'b1)
      rd(A_STA);
      `CHK(rdat, 32'h00000001)
      @(negedge aclk);
      `CHK(irq, 1'b0)
      thr = 5'($urandom_range(15, 1));
      wr(A_CTL, ctl(1, 1, 1, 0, 1, thr));
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         push(16'($urandom));
         rd(A_CTL);
         `CHK(rdat[12:8], 5'(i + 1))
      end
      wr(A_CTL, ctl(1, 1, 1, 0, 1, thr));
      rd(A_CTL);
      `CHK(rdat, ectl(1, 1, 1, 5'h10, 1, 1, thr))
      `CHK(tx_level_irq, 1'b1)
      wr(A_CTL, ctl(1, 1, 1, 1, 1, thr));
      wr(A_DAT, 32'h0000BEEF);
      rd(A_CTL);
      `CHK(rdat, ectl(1, 1, 1, 5'h10, 0, 1, thr))
      `CHK(tx_level_irq, 1'b0)
      rd(A_STA);
      `CHK(rdat, 32'h00000002)
      // drain against a slow far side
      @(posedge aclk);
      slow <= 1'b1;
      stall <= 1'b0;
      drained();
      `CHK(q.size(), 0)
      rd(A_CTL);
      `CHK(rdat, ectl(1, 1, 1, 5'h00, 1, 1, thr))
      `CHK(tx_level_irq, 1'b1)
      @(posedge aclk);
      stall <= 1'b1;
      repeat (3) push(16'($urandom));
      wr(A_CTL, ctl(0, 1, 1, 0, 1, thr));
      q.delete();
      @(negedge aclk);
      `CHK(channel_reset_n, 1'b0)
      `CHK(tx_word_valid, 1'b0)
      rd(A_CTL);
      `CHK(rdat, ectl(0, 1, 1, 5'h00, 1, 1, thr))
      rd(A_RX);
      `CHK(rdat, {16'h0000, RX_CTRL_WMASK})
      wr(A_CTL, ctl(1, 1, 1, 0, 1, thr));
      push(16'($urandom));
      @(negedge aclk);
      `CHK(channel_reset_n, 1'b1)
      `CHK(tx_word_valid, 1'b1)
      // random bursts with the far side running
      @(posedge aclk);
      stall <= 1'b0;
      repeat (6) begin
         slow <= 1'($urandom);
         n = $urandom_range(8, 1);
         repeat (n) push(16'($urandom));
      end
      drained();
      `CHK(q.size(), 0)
      conclude;
   end
endmodule
